// file: design/upcs_pkg.sv
// package with register map, field layout and carrier types for the port connect/enable status block
// What this block does
// - in host mode the enable change flag is set only when the port becomes disabled by disconnect or end-of-frame fault.
// - software clears the enable change flag by writing one to it and the block clears it on that write.
// - in device mode the enable change flag reads zero.
// - in host mode with port power off, connect status, connect change, enabled and enable change read zero.
// - in host mode a software write of one to the enabled bit does not enable the port.
// - in host mode the port is enabled only by the controller at the end of its reset-and-enable sequence.
// - the enabled bit clears on a fault such as disconnect and on a software write of zero.
// - the enabled bit follows the port state machine and changes only once that state is really entered.
// - while disabled, downstream data traffic is blocked but reset signalling still passes.
// - in device mode the enabled bit reads one.
// - in host mode the connect change flag is set on every change of connect status and stays set.
// - software clears the connect change flag by writing one to it and the block clears it on that write.
// - in device mode the connect change flag is undefined and no logic relies on it.
// - in host mode the connect status reads one while a device is present.
// - in device mode the connect status reads one once attached at high or full speed.
// - in device mode the connect status reads zero on failed attach or run bit cleared, and ignores suspend.
package upcs_pkg;
    localparam logic [11:0] UPCS_ADDR_STATUS_CONTROL = 12'h000;
    localparam logic [11:0] UPCS_ADDR_IRQ_STATUS     = 12'h004;
    localparam logic [11:0] UPCS_ADDR_IRQ_MASK       = 12'h008;
    localparam logic [11:0] UPCS_ADDR_CONTROL        = 12'h00C;

    localparam int UPCS_BIT_CONNECT_PRESENT = 0;
    localparam int UPCS_BIT_CONNECT_CHANGE  = 1;
    localparam int UPCS_BIT_PORT_ENABLED    = 2;
    localparam int UPCS_BIT_ENABLE_CHANGE   = 3;
    localparam int UPCS_BIT_PORT_POWER      = 12;
    localparam int UPCS_BIT_RUN             = 0;
    localparam int UPCS_BIT_HOST_MODE       = 1;

    localparam int UPCS_IRQ_CONNECT_CHANGE = 0;
    localparam int UPCS_IRQ_ENABLE_CHANGE  = 1;
    localparam int UPCS_IRQ_BITS           = 2;

    localparam logic [31:0] UPCS_RESET_CONTROL = 32'h0000_0000;
    localparam logic [31:0] UPCS_READ_ZERO     = 32'h0000_0000;

    // requests from the port state machine
    typedef struct packed {
        logic devicePresent;
        logic resetEnableDone;
        logic portFault;
        logic disabledEntered;
        logic attached;
    } upcs_port_in_t;

    // traffic into the downstream data path
    typedef struct packed {
        logic dataValid;
        logic resetSignal;
    } upcs_down_t;
endpackage

// file: design/upcs_port_status.sv
// port connect and enable status bits behind an apb slave
`timescale 1ns/1ps
module upcs_port_status #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // port side, from other clock domains
    input  wire upcs_pkg::upcs_port_in_t portIn,
    input  wire upcs_pkg::upcs_down_t    downIn,
    // gated downstream traffic
    output upcs_pkg::upcs_down_t         downOut,
    // controller side
    output logic                       hostMode,
    output logic                       runBit,
    output logic                       portPower,
    output logic                       disableReq,
    output logic                       irq
);
    // elaboration checks: the decode looks at twelve address bits and every field must fit one word
    initial begin
        if (ADDR_W < 4) begin
            $error("ADDR_W too small");
        end
        if (ADDR_W > 32) begin
            $error("ADDR_W too large");
        end
        if (upcs_pkg::UPCS_IRQ_BITS < 1 || upcs_pkg::UPCS_IRQ_BITS > 32) begin
            $error("irq field does not fit a word");
        end
        if (upcs_pkg::UPCS_BIT_PORT_POWER > 31) begin
            $error("port power bit outside the word");
        end
        if (upcs_pkg::UPCS_BIT_HOST_MODE > 31 || upcs_pkg::UPCS_BIT_RUN > 31) begin
            $error("control bits outside the word");
        end
        if (upcs_pkg::UPCS_BIT_ENABLE_CHANGE > 31) begin
            $error("status bits outside the word");
        end
    end

    // synchronisers
    upcs_pkg::upcs_port_in_t portMeta_q;
    upcs_pkg::upcs_port_in_t portSync_q;
    upcs_pkg::upcs_down_t    downMeta_q;
    upcs_pkg::upcs_down_t    downSync_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            portMeta_q <= '0;
            portSync_q <= '0;
            downMeta_q <= '0;
            downSync_q <= '0;
        end else begin
            portMeta_q <= portIn;
            portSync_q <= portMeta_q;
            downMeta_q <= downIn;
            downSync_q <= downMeta_q;
        end
    end

    // apb decode
    logic access;
    logic wrEn;
    logic rdEn;
    logic [11:0] addr12;
    logic mapped;
    assign access = psel && penable && pready;
    assign wrEn   = access && pwrite;
    assign rdEn   = access && !pwrite;
    assign addr12 = 12'(paddr);
    logic hitStatus;
    logic hitIrq;
    logic hitMask;
    logic hitCtrl;
    assign hitStatus = addr12 == upcs_pkg::UPCS_ADDR_STATUS_CONTROL;
    assign hitIrq    = addr12 == upcs_pkg::UPCS_ADDR_IRQ_STATUS;
    assign hitMask   = addr12 == upcs_pkg::UPCS_ADDR_IRQ_MASK;
    assign hitCtrl   = addr12 == upcs_pkg::UPCS_ADDR_CONTROL;
    assign mapped    = hitStatus || hitIrq || hitMask || hitCtrl;

    logic wrStatus;
    logic wrMask;
    logic wrCtrl;
    logic rdIrq;
    assign wrStatus = wrEn && addr12 == upcs_pkg::UPCS_ADDR_STATUS_CONTROL;
    assign wrMask   = wrEn && addr12 == upcs_pkg::UPCS_ADDR_IRQ_MASK;
    assign wrCtrl   = wrEn && addr12 == upcs_pkg::UPCS_ADDR_CONTROL;
    assign rdIrq    = rdEn && addr12 == upcs_pkg::UPCS_ADDR_IRQ_STATUS;

    // control: run bit and mode
    logic [31:0] ctrl_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= upcs_pkg::UPCS_RESET_CONTROL;
        end else if (wrCtrl) begin
            ctrl_q <= pwdata;
        end
    end
    logic isHost;
    logic isRun;
    assign isHost = ctrl_q[upcs_pkg::UPCS_BIT_HOST_MODE];
    assign isRun  = ctrl_q[upcs_pkg::UPCS_BIT_RUN];

    // port power
    logic power_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            power_q <= 1'b0;
        end else if (wrStatus) begin
            power_q <= pwdata[upcs_pkg::UPCS_BIT_PORT_POWER];
        end
    end

    logic live;
    assign live = isHost && power_q;

    // connect status
    logic present_q;
    logic presentNow;
    assign presentNow = isHost ? (power_q && portSync_q.devicePresent)
                               : (isRun && portSync_q.attached);
    always_ff @(posedge clk) begin
        if (rst) begin
            present_q <= 1'b0;
        end else begin
            present_q <= presentNow;
        end
    end

    // connect change
    logic connChg_q;
    logic connSet;
    assign connSet = live && (presentNow != present_q);
    always_ff @(posedge clk) begin
        if (rst || !live) begin
            connChg_q <= 1'b0;
        end else if (connSet) begin
            connChg_q <= 1'b1;
        end else if (wrStatus && pwdata[upcs_pkg::UPCS_BIT_CONNECT_CHANGE]) begin
            connChg_q <= 1'b0;
        end
    end

    // port enabled, follows the port state machine
    logic enabled_q;
    logic disEvent;
    logic faultSeen;
    logic deviceGone;
    // only a disconnect or a bus fault flags a change; a software disable does not
    assign faultSeen  = portSync_q.portFault;
    assign deviceGone = !presentNow;
    assign disEvent   = live && enabled_q && portSync_q.disabledEntered && (faultSeen || deviceGone);
    always_ff @(posedge clk) begin
        if (rst || !live) begin
            enabled_q <= 1'b0;
        end else if (portSync_q.disabledEntered) begin
            enabled_q <= 1'b0;
        end else if (portSync_q.resetEnableDone) begin
            enabled_q <= 1'b1;
        end
    end

    // software disable request, held until the state machine reports disabled
    logic disReq_q;
    always_ff @(posedge clk) begin
        if (rst || !live) begin
            disReq_q <= 1'b0;
        end else if (wrStatus && !pwdata[upcs_pkg::UPCS_BIT_PORT_ENABLED] && enabled_q) begin
            disReq_q <= 1'b1;
        end else if (portSync_q.disabledEntered || !enabled_q) begin
            disReq_q <= 1'b0;
        end
    end

    // enable change
    logic enChg_q;
    always_ff @(posedge clk) begin
        if (rst || !live) begin
            enChg_q <= 1'b0;
        end else if (disEvent) begin
            enChg_q <= 1'b1;
        end else if (wrStatus && pwdata[upcs_pkg::UPCS_BIT_ENABLE_CHANGE]) begin
            enChg_q <= 1'b0;
        end
    end

    logic enabledView;
    assign enabledView = isHost ? enabled_q : 1'b1;

    // downstream gating
    always_ff @(posedge clk) begin
        if (rst) begin
            downOut <= '0;
        end else begin
            downOut.dataValid   <= downSync_q.dataValid && enabledView;
            downOut.resetSignal <= downSync_q.resetSignal;
        end
    end

    // interrupt status and mask
    logic [upcs_pkg::UPCS_IRQ_BITS-1:0] irqSt_q;
    logic [upcs_pkg::UPCS_IRQ_BITS-1:0] irqMask_q;
    logic [upcs_pkg::UPCS_IRQ_BITS-1:0] irqEv;
    assign irqEv[upcs_pkg::UPCS_IRQ_CONNECT_CHANGE] = connSet;
    assign irqEv[upcs_pkg::UPCS_IRQ_ENABLE_CHANGE]  = disEvent;
    genvar gi;
    generate
        for (gi = 0; gi < upcs_pkg::UPCS_IRQ_BITS; gi++) begin : g_irq
            always_ff @(posedge clk) begin
                if (rst) begin
                    irqSt_q[gi] <= 1'b0;
                end else if (irqEv[gi]) begin
                    irqSt_q[gi] <= 1'b1;
                end else if (rdIrq) begin
                    irqSt_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate
    always_ff @(posedge clk) begin
        if (rst) begin
            irqMask_q <= '0;
        end else if (wrMask) begin
            irqMask_q <= pwdata[upcs_pkg::UPCS_IRQ_BITS-1:0];
        end
    end
    // a read clears the sticky bits, but an event in the same cycle keeps its bit
    logic [upcs_pkg::UPCS_IRQ_BITS-1:0] irqClr;
    logic [upcs_pkg::UPCS_IRQ_BITS-1:0] irqNext;
    logic                               irqLevel;
    always_comb begin
        irqClr   = {upcs_pkg::UPCS_IRQ_BITS{rdIrq}} & ~irqEv;
        irqNext  = (irqSt_q | irqEv) & ~irqClr;
        irqLevel = |(irqNext & irqMask_q);
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= irqLevel;
        end
    end

    // status word as software sees it
    logic [31:0] statusWord;
    always_comb begin
        statusWord = upcs_pkg::UPCS_READ_ZERO;
        statusWord[upcs_pkg::UPCS_BIT_CONNECT_PRESENT] = present_q;
        statusWord[upcs_pkg::UPCS_BIT_CONNECT_CHANGE]  = connChg_q;
        statusWord[upcs_pkg::UPCS_BIT_PORT_ENABLED]    = enabledView;
        statusWord[upcs_pkg::UPCS_BIT_ENABLE_CHANGE]   = enChg_q;
        statusWord[upcs_pkg::UPCS_BIT_PORT_POWER]      = power_q;
    end

    // read mux
    logic [31:0] rdVal;
    always_comb begin
        rdVal = upcs_pkg::UPCS_READ_ZERO;
        case (addr12)
            upcs_pkg::UPCS_ADDR_STATUS_CONTROL: begin
                rdVal = statusWord;
            end
            upcs_pkg::UPCS_ADDR_IRQ_STATUS: begin
                rdVal[upcs_pkg::UPCS_IRQ_BITS-1:0] = irqSt_q;
            end
            upcs_pkg::UPCS_ADDR_IRQ_MASK: begin
                rdVal[upcs_pkg::UPCS_IRQ_BITS-1:0] = irqMask_q;
            end
            upcs_pkg::UPCS_ADDR_CONTROL: begin
                rdVal = ctrl_q;
            end
            default: begin
                rdVal = upcs_pkg::UPCS_READ_ZERO;
            end
        endcase
    end

    // apb answer: no wait state, ready in the first access cycle
    logic        setupPhase;
    logic        readyNext;
    logic        errNext;
    logic [31:0] dataNext;
    always_comb begin
        setupPhase = psel && !penable;
        readyNext  = setupPhase;
        errNext    = setupPhase && !mapped;
        dataNext   = upcs_pkg::UPCS_READ_ZERO;
        if (setupPhase && !pwrite) begin
            dataNext = rdVal;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= upcs_pkg::UPCS_READ_ZERO;
            pslverr <= 1'b0;
        end else begin
            pready  <= readyNext;
            prdata  <= dataNext;
            pslverr <= errNext;
        end
    end

    // controller side outputs: mode and run bit
    always_ff @(posedge clk) begin
        if (rst) begin
            hostMode <= 1'b0;
            runBit   <= 1'b0;
        end else begin
            hostMode <= isHost;
            runBit   <= isRun;
        end
    end

    // port power to the port switch
    always_ff @(posedge clk) begin
        if (rst) begin
            portPower <= 1'b0;
        end else begin
            portPower <= power_q;
        end
    end

    // disable request to the port state machine
    always_ff @(posedge clk) begin
        if (rst) begin
            disableReq <= 1'b0;
        end else begin
            disableReq <= disReq_q;
        end
    end
endmodule

// file: testbench/upcs_port_status_assertions.sv
// concurrent checks on the port status block ports
`timescale 1ns/1ps
module upcs_port_status_assertions #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 rst,
    // apb
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [ADDR_W-1:0]    paddr,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    // port and controller
    input wire upcs_pkg::upcs_down_t downIn,
    input wire upcs_pkg::upcs_down_t downOut,
    input wire logic                 hostMode,
    input wire logic                 portPower
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence setupSeq;
        psel && !penable;
    endsequence
    sequence statRd;
        pready && !pwrite && !pslverr && paddr == upcs_pkg::UPCS_ADDR_STATUS_CONTROL;
    endsequence
    ready_after_setup_a: assert property (setupSeq |=> pready)
        else $error("pready missing after setup");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    addr_decode_a: assert property (pready |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C}))
        else $error("pslverr wrong for address");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside access");
    dev_status_a: assert property (statRd ##0 !hostMode |-> prdata[2] && !prdata[3])
        else $error("device mode enable bits wrong");
    host_unpowered_a: assert property (statRd ##0 (hostMode && !portPower) |-> prdata[3:0] == 4'h0)
        else $error("status bits set without port power");
    reset_passes_a: assert property (downOut.resetSignal == $past(downIn.resetSignal, 3))
        else $error("reset signalling not passed");
    dev_data_a: assert property (!hostMode && $past(!hostMode, 4) |-> downOut.dataValid == $past(downIn.dataValid, 3))
        else $error("device data not passed");
endmodule
bind upcs_port_status upcs_port_status_assertions #(.ADDR_W(ADDR_W)) i_chk (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .downIn(downIn), .downOut(downOut), .hostMode(hostMode), .portPower(portPower));

// file: testbench/upcs_usb_peer.sv
// behavioural usb peer and port state machine on the far side
`timescale 1ns/1ps
module upcs_usb_peer #(
    parameter int LAG = 20
) (
    // clock
    input  wire logic               clk,
    // controller request
    input  wire logic               disableReq,
    // port side
    output upcs_pkg::upcs_port_in_t portIn,
    output upcs_pkg::upcs_down_t    downIn
);
    int cnt = 0;
    initial portIn = '0;
    initial downIn = '0;
    // the disabled state is reached well after the request
    always @(posedge clk) begin
        cnt <= disableReq ? cnt + 1 : 0;
        if (cnt == LAG) begin
            portIn.disabledEntered <= 1'b1;
        end
    end
    task automatic plug(input logic p);
        @(posedge clk);
        portIn.devicePresent <= p;
        portIn.attached <= p;
        portIn.portFault <= !p;
        if (!p) begin
            portIn.disabledEntered <= 1'b1;
        end
    endtask
    task automatic enableDone();
        @(posedge clk);
        portIn.disabledEntered <= 1'b0;
        repeat (3) @(posedge clk);
        portIn.resetEnableDone <= 1'b1;
        @(posedge clk);
        portIn.resetEnableDone <= 1'b0;
    endtask
    task automatic data(input logic v, input logic r);
        @(posedge clk);
        downIn <= '{dataValid: v, resetSignal: r};
    endtask
endmodule

// file: testbench/usb_port_connect_enable_status_test.sv
// self-checking bench for the port connect and enable status block
`timescale 1ns/1ps
module usb_port_connect_enable_status_test;
    localparam logic [11:0] ST = upcs_pkg::UPCS_ADDR_STATUS_CONTROL;
    localparam logic [11:0] CT = upcs_pkg::UPCS_ADDR_CONTROL;
    logic                    clk = 1'b0, rst, psel, penable, pwrite;
    logic [11:0]             paddr;
    logic [31:0]             pwdata, prdata, rd;
    logic                    pready, pslverr, rdErr, hostMode, runBit, portPower, disableReq, irq, irqA;
    upcs_pkg::upcs_port_in_t portIn;
    upcs_pkg::upcs_down_t    downIn, downOut;
    int                      miscompares = 0, n_checks = 0;
    upcs_port_status i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .portIn(portIn), .downIn(downIn),
        .downOut(downOut), .hostMode(hostMode), .runBit(runBit), .portPower(portPower), .disableReq(disableReq),
        .irq(irq));
    upcs_usb_peer i_peer (.clk(clk), .disableReq(disableReq), .portIn(portIn), .downIn(downIn));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdChk(input string n, input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
        repeat (5) @(posedge clk);
        apb(1'b0, a, 32'h0);
        check(n, e, rd & m);
    endtask
    task automatic testDevice();
        rdChk("control", CT, 32'h0);
        rdChk("dev idle", ST, 32'h4, 32'hFFFFFFFD);
        rdChk("unmapped", 12'h010, 32'h0);
        check("slverr", 32'h1, {31'h0, rdErr});
        i_peer.plug(1'b1);
        apb(1'b1, CT, 32'h1);
        rdChk("dev attached", ST, 32'h5, 32'hFFFFFFFD);
        apb(1'b1, CT, 32'h0);
        rdChk("dev run off", ST, 32'h4, 32'hFFFFFFFD);
        i_peer.plug(1'b0);
    endtask
    task automatic testConnect();
        apb(1'b1, CT, 32'h2);
        rdChk("host unpowered", ST, 32'h0);
        apb(1'b1, ST, 32'h1002);
        rdChk("host empty", ST, 32'h1000);
        apb(1'b1, ST, 32'h1004);
        rdChk("no sw enable", ST, 32'h1000);
        i_peer.plug(1'b1);
        i_peer.plug(1'b0);
        i_peer.plug(1'b1);
        rdChk("present", ST, 32'h1003);
        apb(1'b1, ST, 32'h1000);
        rdChk("zero write", ST, 32'h1003);
        apb(1'b1, upcs_pkg::UPCS_ADDR_IRQ_MASK, 32'h0);
        repeat (4) @(posedge clk);
        irqA = irq;
        apb(1'b1, upcs_pkg::UPCS_ADDR_IRQ_MASK, 32'h3);
        repeat (4) @(posedge clk);
        check("irq mask", 32'h1, {31'h0, irqA ^ irq});
        rdChk("irq status", upcs_pkg::UPCS_ADDR_IRQ_STATUS, 32'h1);
        rdChk("irq cleared", upcs_pkg::UPCS_ADDR_IRQ_STATUS, 32'h0);
        check("irq low", 32'h0, {31'h0, irq});
        apb(1'b1, ST, 32'h1002);
        rdChk("csc cleared", ST, 32'h1001);
        apb(1'b1, ST, 32'h0);
        rdChk("power off", ST, 32'h0);
        apb(1'b1, ST, 32'h1000);
        rdChk("repower change", ST, 32'h1003);
        apb(1'b1, ST, 32'h1002);
    endtask
    task automatic testEnable();
        i_peer.enableDone();
        i_peer.data(1'b1, 1'b0);
        rdChk("enabled", ST, 32'h1005);
        check("data on", 32'h1, {31'h0, downOut.dataValid});
        apb(1'b1, ST, 32'h1000);
        rdChk("disable lag", ST, 32'h1005);
        check("disable req", 32'h1, {31'h0, disableReq});
        repeat (30) @(posedge clk);
        rdChk("sw disabled", ST, 32'h1001);
        check("data off", 32'h0, {31'h0, downOut.dataValid});
        i_peer.enableDone();
        i_peer.plug(1'b0);
        i_peer.data(1'b1, 1'b1);
        rdChk("fault", ST, 32'h100A);
        check("reset on", 32'h1, {31'h0, downOut.resetSignal});
        apb(1'b1, ST, 32'h1008);
        rdChk("pec cleared", ST, 32'h1002);
    endtask
    task automatic results();
        if (miscompares == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        testDevice();
        testConnect();
        testEnable();
        results();
    end
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        results();
    end
endmodule
